// ===== shared/occ_pkg.sv
// Package with register map, field layout, reset values and timing counts
package occ_pkg;

	// ==========================================================
	// Clock and timing
	// ==========================================================
	localparam int CLK_PERIOD_NS  = 40;      // 25 MHz system clock
	localparam int LF_TIMEOUT_NS  = 100000;  // No LF edge for 100 us
	localparam int HF_TIMEOUT_NS  = 10000;   // No HF edge for 10 us
	localparam int SWITCH_GAP_NS  = 200;     // CPU clock gap on a switch
	localparam int VLO_TYP_HZ     = 12000;   // Very-low-power osc, typical
	// Least times round up to whole cycles
	localparam int LF_TIMEOUT_CYC =
		(LF_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HF_TIMEOUT_CYC =
		(HF_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SWITCH_GAP_CYC =
		(SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Register byte addresses
	// ==========================================================
	localparam logic [7:0] ADDR_CTRL_ONE   = 8'h00;
	localparam logic [7:0] ADDR_CTRL_TWO   = 8'h04;
	localparam logic [7:0] ADDR_CTRL_THREE = 8'h08;
	localparam logic [7:0] ADDR_TAP_MOD    = 8'h0C;
	localparam logic [7:0] ADDR_STATUS     = 8'h10;
	localparam logic [7:0] ADDR_MASK       = 8'h14;
	localparam logic [7:0] ADDR_STATE      = 8'h18;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int RANGE_LSB    = 0;  // clock_ctrl_one [3:0]
	localparam int HF_OFF_BIT   = 4;  // clock_ctrl_one [4]
	localparam int CPU_SRC_LSB  = 0;  // clock_ctrl_two [1:0]
	localparam int EXT_BIAS_BIT = 2;  // clock_ctrl_two [2]
	localparam int HF_RANGE_LSB = 0;  // clock_ctrl_three [1:0]
	localparam int LF_CAP_LSB   = 2;  // clock_ctrl_three [3:2]
	localparam int LF_SEL_LO    = 4;  // clock_ctrl_three [4]
	localparam int LF_SEL_HI    = 5;  // clock_ctrl_three [5]
	localparam int MOD_LSB      = 0;  // tap/mod [4:0]
	localparam int TAP_LSB      = 5;  // tap/mod [7:5]
	localparam int EV_LF_FAULT  = 0;  // status / mask
	localparam int EV_HF_FAULT  = 1;
	localparam int EV_GLOBAL    = 2;
	localparam int EV_W         = 3;

	// ==========================================================
	// Reset values and encodings
	// ==========================================================
	localparam logic [3:0] RANGE_RST    = 4'h7;  // Around 1.2 MHz
	localparam logic [2:0] TAP_RST      = 3'h3;
	localparam logic [4:0] MOD_RST      = 5'h00;
	localparam logic [1:0] HF_RANGE_RST = 2'h0;  // 0.4 MHz to 1 MHz
	localparam logic [1:0] LF_CAP_RST   = 2'h1;  // Effective 6 pF
	localparam logic [1:0] LF_MODE_XTAL = 2'h0;
	localparam logic [1:0] LF_MODE_VLO  = 2'h2;
	localparam logic [1:0] LF_MODE_DIG  = 2'h3;  // Direct digital input
	localparam logic [1:0] SRC_DCO      = 2'h0;
	localparam logic [1:0] SRC_LF       = 2'h1;
	localparam logic [1:0] SRC_HF       = 2'h2;

	// CPU clock switch states
	typedef enum logic [3:0]
	{
		ST_RUN_DCO = 4'h1,
		ST_RUN_LF  = 4'h2,
		ST_RUN_HF  = 4'h4,
		ST_GAP     = 4'h8
	} occ_state_t;

endpackage

// ===== hw/occ_activity_monitor.sv
// Oscillator activity monitor that flags a missing edge
`timescale 1ns/1ps

module occ_activity_monitor
#(
	parameter int TIMEOUT_CYCLES = 2500
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic enable,
	input  wire logic osc_sample,
	output logic      fault
);

	localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
	localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT_CYCLES);

	logic          prev_sample;
	logic [CW-1:0] idle_count;
	logic          edge_seen;

	// ==========================================================
	// Edge detection
	// ==========================================================
	assign edge_seen = osc_sample ^ prev_sample;

	// Previous sample for edge compare
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prev_sample <= 1'b0;
		else
			prev_sample <= osc_sample;
	end

	// Idle counter, restarts on every edge, saturates at the limit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			idle_count <= '0;
		else if (!enable || edge_seen)
			idle_count <= '0;
		else if (idle_count != LIMIT)
			idle_count <= idle_count + 1'b1;
	end

	// Fault level while the oscillator stays silent too long
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			fault <= 1'b0;
		else
			fault <= enable && !edge_seen && (idle_count == LIMIT);
	end

endmodule

// ===== hw/occ_clock_control.sv
// Oscillator clock control with APB registers and CPU clock selection
`timescale 1ns/1ps

module occ_clock_control
#(
	parameter int LF_TIMEOUT = occ_pkg::LF_TIMEOUT_CYC,
	parameter int HF_TIMEOUT = occ_pkg::HF_TIMEOUT_CYC,
	parameter int SWITCH_GAP = occ_pkg::SWITCH_GAP_CYC
)
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        lf_osc_sample,
	input  wire logic        hf_osc_sample,
	input  wire logic        vlo_sample,
	output logic [3:0]       osc_range_select,
	output logic [2:0]       osc_tap_select,
	output logic [4:0]       osc_modulation_select,
	output logic             external_bias_select,
	output logic [1:0]       hf_range_select,
	output logic [1:0]       lf_load_cap_select,
	output logic             lf_source_select_hi,
	output logic             lf_source_select_lo,
	output logic             lf_digital_input_en,
	output logic             very_low_power_osc_en,
	output logic             high_freq_osc_en,
	output logic [1:0]       cpu_clk_source,
	output logic             cpu_clk_enable,
	output logic             irq
);

	localparam int GW = $clog2(SWITCH_GAP + 1);
	localparam logic [GW-1:0] GAP_LAST = GW'(SWITCH_GAP - 1);

	// Software-visible control
	logic [3:0]          range_sel;
	logic                hf_off;
	logic [1:0]          cpu_src_req;
	logic                ext_bias;
	logic [1:0]          hf_range;
	logic [1:0]          lf_cap;
	logic [1:0]          lf_mode;
	logic [2:0]          tap_sel;
	logic [4:0]          mod_sel;
	logic [occ_pkg::EV_W-1:0] status;
	logic [occ_pkg::EV_W-1:0] mask;

	// Internal state
	logic                lf_fault;
	logic                hf_fault;
	logic                lf_fault_d;
	logic                hf_fault_d;
	logic                lf_monitor_in;
	occ_pkg::occ_state_t state;
	occ_pkg::occ_state_t next_state;
	logic [1:0]          target_src;
	logic [1:0]          pending_src;
	logic [GW-1:0]       gap_count;

	// Bus decode
	logic                setup_phase;
	logic                wr_en;
	logic                addr_hit;
	logic [31:0]         rd_value;
	logic [occ_pkg::EV_W-1:0] ev_set;
	logic [occ_pkg::EV_W-1:0] ev_clr;

	// ==========================================================
	// Helpers
	// ==========================================================
	// Source code that belongs to a running state
	function automatic logic [1:0] src_of(input occ_pkg::occ_state_t s);
		case (s)
			occ_pkg::ST_RUN_LF: src_of = occ_pkg::SRC_LF;
			occ_pkg::ST_RUN_HF: src_of = occ_pkg::SRC_HF;
			default:            src_of = occ_pkg::SRC_DCO;
		endcase
	endfunction

	// Running state that belongs to a source code
	function automatic occ_pkg::occ_state_t run_of(input logic [1:0] s);
		case (s)
			occ_pkg::SRC_LF: run_of = occ_pkg::ST_RUN_LF;
			occ_pkg::SRC_HF: run_of = occ_pkg::ST_RUN_HF;
			default:         run_of = occ_pkg::ST_RUN_DCO;
		endcase
	endfunction

	// ==========================================================
	// APB slave
	// ==========================================================
	assign pready      = 1'b1;
	assign setup_phase = psel && !penable;
	assign wr_en       = psel && penable && pwrite && addr_hit;

	// Known addresses; anything else answers with an error
	always_comb
	begin
		case (paddr)
			occ_pkg::ADDR_CTRL_ONE,
			occ_pkg::ADDR_CTRL_TWO,
			occ_pkg::ADDR_CTRL_THREE,
			occ_pkg::ADDR_TAP_MOD,
			occ_pkg::ADDR_STATUS,
			occ_pkg::ADDR_MASK,
			occ_pkg::ADDR_STATE: addr_hit = 1'b1;
			default:             addr_hit = 1'b0;
		endcase
	end

	assign pslverr = psel && penable && !addr_hit;

	// Read multiplexer, unused bits read as zero
	always_comb
	begin
		rd_value = 32'h0000_0000;
		case (paddr)
			occ_pkg::ADDR_CTRL_ONE:
			begin
				rd_value[occ_pkg::RANGE_LSB +: 4] = range_sel;
				rd_value[occ_pkg::HF_OFF_BIT]     = hf_off;
			end
			occ_pkg::ADDR_CTRL_TWO:
			begin
				rd_value[occ_pkg::CPU_SRC_LSB +: 2] = cpu_src_req;
				rd_value[occ_pkg::EXT_BIAS_BIT]     = ext_bias;
			end
			occ_pkg::ADDR_CTRL_THREE:
			begin
				rd_value[occ_pkg::HF_RANGE_LSB +: 2] = hf_range;
				rd_value[occ_pkg::LF_CAP_LSB +: 2]   = lf_cap;
				rd_value[occ_pkg::LF_SEL_LO +: 2]    = lf_mode;
			end
			occ_pkg::ADDR_TAP_MOD:
			begin
				rd_value[occ_pkg::TAP_LSB +: 3] = tap_sel;
				rd_value[occ_pkg::MOD_LSB +: 5] = mod_sel;
			end
			occ_pkg::ADDR_STATUS:
				rd_value[occ_pkg::EV_W-1:0] = status;
			occ_pkg::ADDR_MASK:
				rd_value[occ_pkg::EV_W-1:0] = mask;
			occ_pkg::ADDR_STATE:
			begin
				rd_value[1:0] = src_of(state);
				rd_value[2]   = (state == occ_pkg::ST_GAP);
				rd_value[3]   = lf_fault;
				rd_value[4]   = hf_fault;
				rd_value[5]   = (lf_mode == occ_pkg::LF_MODE_DIG);
			end
			default:
				rd_value = 32'h0000_0000;
		endcase
	end

	// Read data captured in the setup cycle, valid through access
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prdata <= 32'h0000_0000;
		else if (setup_phase && !pwrite)
			prdata <= rd_value;
	end

	// ==========================================================
	// Control registers
	// ==========================================================
	// First control register: range field and HF oscillator off
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			range_sel <= occ_pkg::RANGE_RST;
			hf_off    <= 1'b1;
		end
		else if (wr_en && paddr == occ_pkg::ADDR_CTRL_ONE)
		begin
			range_sel <= pwdata[occ_pkg::RANGE_LSB +: 4];
			hf_off    <= pwdata[occ_pkg::HF_OFF_BIT];
		end
	end

	// Second control register: CPU source request and bias mode
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpu_src_req <= occ_pkg::SRC_DCO;
			ext_bias    <= 1'b0;
		end
		else if (wr_en && paddr == occ_pkg::ADDR_CTRL_TWO)
		begin
			cpu_src_req <= pwdata[occ_pkg::CPU_SRC_LSB +: 2];
			ext_bias    <= pwdata[occ_pkg::EXT_BIAS_BIT];
		end
	end

	// Third control register: HF range, LF load cap and LF source
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hf_range <= occ_pkg::HF_RANGE_RST;
			lf_cap   <= occ_pkg::LF_CAP_RST;
			lf_mode  <= occ_pkg::LF_MODE_XTAL;
		end
		else if (wr_en && paddr == occ_pkg::ADDR_CTRL_THREE)
		begin
			hf_range <= pwdata[occ_pkg::HF_RANGE_LSB +: 2];
			lf_cap   <= pwdata[occ_pkg::LF_CAP_LSB +: 2];
			lf_mode  <= pwdata[occ_pkg::LF_SEL_LO +: 2];
		end
	end

	// Tap and modulation fields, where calibration words land
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tap_sel <= occ_pkg::TAP_RST;
			mod_sel <= occ_pkg::MOD_RST;
		end
		else if (wr_en && paddr == occ_pkg::ADDR_TAP_MOD)
		begin
			tap_sel <= pwdata[occ_pkg::TAP_LSB +: 3];
			mod_sel <= pwdata[occ_pkg::MOD_LSB +: 5];
		end
	end

	// Interrupt mask
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mask <= '0;
		else if (wr_en && paddr == occ_pkg::ADDR_MASK)
			mask <= pwdata[occ_pkg::EV_W-1:0];
	end

	// ==========================================================
	// Oscillator fault detection
	// ==========================================================
	// LF monitor watches the internal oscillator when it is selected
	assign lf_monitor_in = (lf_mode == occ_pkg::LF_MODE_VLO) ?
		vlo_sample : lf_osc_sample;

	occ_activity_monitor
	#(
		.TIMEOUT_CYCLES (LF_TIMEOUT)
	)
	u_lf_monitor
	(
		.clk        (clk),
		.rst_n      (rst_n),
		.enable     (1'b1),
		.osc_sample (lf_monitor_in),
		.fault      (lf_fault)
	);

	occ_activity_monitor
	#(
		.TIMEOUT_CYCLES (HF_TIMEOUT)
	)
	u_hf_monitor
	(
		.clk        (clk),
		.rst_n      (rst_n),
		.enable     (!hf_off),
		.osc_sample (hf_osc_sample),
		.fault      (hf_fault)
	);

	// Delayed fault levels for onset detection
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lf_fault_d <= 1'b0;
			hf_fault_d <= 1'b0;
		end
		else
		begin
			lf_fault_d <= lf_fault;
			hf_fault_d <= hf_fault;
		end
	end

	// ==========================================================
	// Sticky status and interrupt
	// ==========================================================
	// Fault onsets set their own flag; any fault level sets global
	always_comb
	begin
		ev_set = '0;
		ev_set[occ_pkg::EV_LF_FAULT] = lf_fault && !lf_fault_d;
		ev_set[occ_pkg::EV_HF_FAULT] = hf_fault && !hf_fault_d;
		ev_set[occ_pkg::EV_GLOBAL]   = lf_fault || hf_fault;
	end

	assign ev_clr = (wr_en && paddr == occ_pkg::ADDR_STATUS) ?
		pwdata[occ_pkg::EV_W-1:0] : '0;

	// Write one to clear; a set in the same cycle wins
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			status <= '0;
		else
			status <= (status & ~ev_clr) | ev_set;
	end

	// Level interrupt from unmasked status bits
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(((status & ~ev_clr) | ev_set) & mask);
	end

	// ==========================================================
	// CPU clock source selection
	// ==========================================================
	// Global fault forces the internal oscillator; code 3 maps to it
	assign target_src = status[occ_pkg::EV_GLOBAL] ?
		occ_pkg::SRC_DCO : src_of(run_of(cpu_src_req));

	// Switch sequencer with a gated gap between sources
	always_comb
	begin
		next_state = state;
		case (state)
			occ_pkg::ST_RUN_DCO,
			occ_pkg::ST_RUN_LF,
			occ_pkg::ST_RUN_HF:
				if (target_src != src_of(state))
					next_state = occ_pkg::ST_GAP;
			occ_pkg::ST_GAP:
				if (gap_count == GAP_LAST)
					next_state = run_of(pending_src);
			default:
				next_state = occ_pkg::ST_RUN_DCO;
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= occ_pkg::ST_RUN_DCO;
		else
			state <= next_state;
	end

	// Gap counter and the source latched when the gap begins
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gap_count   <= '0;
			pending_src <= occ_pkg::SRC_DCO;
		end
		else if (state != occ_pkg::ST_GAP)
		begin
			gap_count   <= '0;
			pending_src <= target_src;
		end
		else
		begin
			gap_count <= gap_count + 1'b1;
			if (status[occ_pkg::EV_GLOBAL])
				pending_src <= occ_pkg::SRC_DCO;
		end
	end

	// ==========================================================
	// Oscillator control outputs
	// ==========================================================
	// Registered copies of the fields that steer the oscillators
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_range_select      <= occ_pkg::RANGE_RST;
			osc_tap_select        <= occ_pkg::TAP_RST;
			osc_modulation_select <= occ_pkg::MOD_RST;
			external_bias_select  <= 1'b0;
			hf_range_select       <= occ_pkg::HF_RANGE_RST;
			lf_load_cap_select    <= occ_pkg::LF_CAP_RST;
			lf_source_select_hi   <= 1'b0;
			lf_source_select_lo   <= 1'b0;
			lf_digital_input_en   <= 1'b0;
			very_low_power_osc_en <= 1'b0;
			high_freq_osc_en      <= 1'b0;
			cpu_clk_source        <= occ_pkg::SRC_DCO;
			cpu_clk_enable        <= 1'b1;
		end
		else
		begin
			// Resistor bias uses the narrower legacy range code
			osc_range_select      <= ext_bias ?
				{1'b0, range_sel[2:0]} : range_sel;
			osc_tap_select        <= tap_sel;
			osc_modulation_select <= mod_sel;
			external_bias_select  <= ext_bias;
			hf_range_select       <= hf_range;
			lf_load_cap_select    <= lf_cap;
			lf_source_select_hi   <= lf_mode[1];
			lf_source_select_lo   <= lf_mode[0];
			lf_digital_input_en   <=
				(lf_mode == occ_pkg::LF_MODE_DIG);
			very_low_power_osc_en <=
				(lf_mode == occ_pkg::LF_MODE_VLO);
			high_freq_osc_en      <= !hf_off;
			cpu_clk_source        <= src_of(next_state);
			cpu_clk_enable        <= (next_state != occ_pkg::ST_GAP);
		end
	end

endmodule

// ===== verification/occ_clock_control_monitor.sv
// Checker of port relations for the oscillator clock control
`timescale 1ns/1ps

module occ_clock_control_monitor
#(
	parameter int LF_TIMEOUT = 20,
	parameter int SWITCH_GAP = 2
)
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        lf_osc_sample,
	input wire logic [3:0]  osc_range_select,
	input wire logic [2:0]  osc_tap_select,
	input wire logic [4:0]  osc_modulation_select,
	input wire logic        external_bias_select,
	input wire logic [1:0]  hf_range_select,
	input wire logic [1:0]  lf_load_cap_select,
	input wire logic        lf_source_select_hi,
	input wire logic        lf_source_select_lo,
	input wire logic        lf_digital_input_en,
	input wire logic        very_low_power_osc_en,
	input wire logic [1:0]  cpu_clk_source,
	input wire logic        cpu_clk_enable
);
	localparam int GMAX = SWITCH_GAP + 2;
	localparam int LF_LIM = LF_TIMEOUT + SWITCH_GAP + 10;
	logic wr;
	logic lf_prev;
	int   lf_quiet;

	// ==========================================================
	// Helper logic
	// ==========================================================
	// Write completing in the access phase
	assign wr = psel && penable && pwrite;

	// Cycles since the LF input last changed, saturating
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lf_prev  <= 1'b0;
			lf_quiet <= 0;
		end
		else
		begin
			lf_prev <= lf_osc_sample;
			if (lf_osc_sample != lf_prev)
				lf_quiet <= 0;
			else if (lf_quiet < LF_LIM)
				lf_quiet <= lf_quiet + 1;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_lf_mode;
		lf_digital_input_en == (lf_source_select_hi && lf_source_select_lo)
		&& very_low_power_osc_en == (lf_source_select_hi && !lf_source_select_lo);
	endproperty
	a_lf_mode: assert property (p_lf_mode)
		else $error("LF mode enables disagree with source bits");

	property p_ext_bias;
		external_bias_select |-> osc_range_select[3] == 1'b0;
	endproperty
	a_ext_bias: assert property (p_ext_bias)
		else $error("range top bit set under external bias");

	property p_tap_mod;
		wr && paddr == occ_pkg::ADDR_TAP_MOD |-> ##2
		osc_tap_select == $past(pwdata[7:5], 2)
		&& osc_modulation_select == $past(pwdata[4:0], 2);
	endproperty
	a_tap_mod: assert property (p_tap_mod)
		else $error("tap or modulation output not the written value");

	property p_range;
		wr && paddr == occ_pkg::ADDR_CTRL_ONE |-> ##2
		external_bias_select || osc_range_select == $past(pwdata[3:0], 2);
	endproperty
	a_range: assert property (p_range)
		else $error("range output not the written value");

	property p_ctrl_three;
		wr && paddr == occ_pkg::ADDR_CTRL_THREE |-> ##2
		hf_range_select == $past(pwdata[1:0], 2)
		&& lf_load_cap_select == $past(pwdata[3:2], 2);
	endproperty
	a_ctrl_three: assert property (p_ctrl_three)
		else $error("HF range or LF load output not the written value");

	property p_reset;
		$rose(rst_n) |-> osc_range_select == occ_pkg::RANGE_RST
		&& osc_tap_select == occ_pkg::TAP_RST
		&& hf_range_select == occ_pkg::HF_RANGE_RST
		&& lf_load_cap_select == occ_pkg::LF_CAP_RST;
	endproperty
	a_reset: assert property (p_reset)
		else $error("oscillator fields wrong after reset");

	property p_gap;
		$fell(cpu_clk_enable) |-> ##[1:GMAX] cpu_clk_enable;
	endproperty
	a_gap: assert property (p_gap)
		else $error("CPU clock gap too long");

	property p_fault_dco;
		!very_low_power_osc_en && lf_quiet == LF_LIM
		|-> cpu_clk_source == occ_pkg::SRC_DCO;
	endproperty
	a_fault_dco: assert property (p_fault_dco)
		else $error("CPU not on internal oscillator after LF failure");
endmodule

// ===== verification/occ_osc_model.sv
// Behavioural oscillators driving the clock control sample inputs
`timescale 1ns/1ps

module occ_osc_model
(
	input  wire logic clk,
	input  wire logic lf_run,
	output logic      lf_osc_sample,
	output logic      hf_osc_sample,
	output logic      vlo_sample
);
	logic [3:0] ticks;

	// Start levels
	initial
	begin
		ticks = 4'h0;
		lf_osc_sample = 1'b0;
		hf_osc_sample = 1'b0;
		vlo_sample = 1'b0;
	end

	// A stopped crystal leaves its pin frozen, which the device must catch
	always @(posedge clk)
	begin
		ticks <= ticks + 4'h1;
		if (lf_run && ticks[1:0] == 2'h3)
			lf_osc_sample <= !lf_osc_sample;
		hf_osc_sample <= !hf_osc_sample;
		if (ticks == 4'hF)
			vlo_sample <= !vlo_sample;
	end
endmodule

// ===== verification/occ_clock_control_tb.sv
// Register-level testbench for the oscillator clock control
`timescale 1ns/1ps

module occ_clock_control_tb;
	localparam int LFT = 20;
	localparam int GAP = 2;
	localparam logic [7:0] A_ONE = occ_pkg::ADDR_CTRL_ONE;
	localparam logic [7:0] A_TWO = occ_pkg::ADDR_CTRL_TWO;
	localparam logic [7:0] A_THR = occ_pkg::ADDR_CTRL_THREE;
	localparam logic [7:0] A_TAP = occ_pkg::ADDR_TAP_MOD;
	localparam logic [7:0] A_STS = occ_pkg::ADDR_STATUS;
	localparam logic [7:0] A_MSK = occ_pkg::ADDR_MASK;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr, lf_run;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic lf_osc_sample, hf_osc_sample, vlo_sample;
	logic [3:0] osc_range_select;
	logic [2:0] osc_tap_select;
	logic [4:0] osc_modulation_select;
	logic [1:0] hf_range_select, lf_load_cap_select, cpu_clk_source;
	logic external_bias_select, lf_source_select_hi, lf_source_select_lo;
	logic lf_digital_input_en, very_low_power_osc_en, high_freq_osc_en;
	logic cpu_clk_enable, irq;
	int n_errors, comparisons;

	occ_clock_control #(.LF_TIMEOUT(LFT), .HF_TIMEOUT(10), .SWITCH_GAP(GAP))
	occ_clock_control_i
	(
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lf_osc_sample(lf_osc_sample),
		.hf_osc_sample(hf_osc_sample), .vlo_sample(vlo_sample),
		.osc_range_select(osc_range_select), .osc_tap_select(osc_tap_select),
		.osc_modulation_select(osc_modulation_select),
		.external_bias_select(external_bias_select),
		.hf_range_select(hf_range_select),
		.lf_load_cap_select(lf_load_cap_select),
		.lf_source_select_hi(lf_source_select_hi),
		.lf_source_select_lo(lf_source_select_lo),
		.lf_digital_input_en(lf_digital_input_en),
		.very_low_power_osc_en(very_low_power_osc_en),
		.high_freq_osc_en(high_freq_osc_en), .cpu_clk_source(cpu_clk_source),
		.cpu_clk_enable(cpu_clk_enable), .irq(irq)
	);

	occ_osc_model occ_osc_model_i
	(
		.clk(clk), .lf_run(lf_run), .lf_osc_sample(lf_osc_sample),
		.hf_osc_sample(hf_osc_sample), .vlo_sample(vlo_sample)
	);

	// ==========================================================
	// Clock, tasks and watchdog
	// ==========================================================
	// 25 MHz clock
	always #20 clk = ~clk;

	// Counted comparison of one value
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	// One APB transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		chk("pready", 32'h1, 32'(pready));
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Read and compare one register
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk($sformatf("register %h", a), exp, rdat);
	endtask

	// Let register outputs settle
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Counts and verdict
	task automatic end_of_test;
		$display("comparisons %0d, errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Hang guard, far beyond the expected run
	initial
	begin
		#400000;
		n_errors++;
		end_of_test;
	end

	// ==========================================================
	// Tests
	// ==========================================================
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		lf_run = 1'b1;
		n_errors = 0;
		comparisons = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(A_ONE, 32'h00000017);
		rd(A_THR, 32'h00000004);
		rd(A_TAP, 32'h00000060);
		$display("test reset values done");
		apb(1'b1, A_TAP, 32'h000000B5);
		apb(1'b1, A_ONE, 32'h0000000C);
		wait_n(2);
		chk("tap", 32'h5, 32'(osc_tap_select));
		chk("modulation", 32'h15, 32'(osc_modulation_select));
		chk("range", 32'hC, 32'(osc_range_select));
		chk("hf enable", 32'h1, 32'(high_freq_osc_en));
		apb(1'b1, A_TWO, 32'h00000004);
		wait_n(2);
		chk("biased range", 32'h4, 32'(osc_range_select));
		apb(1'b1, A_TWO, 32'h00000000);
		$display("test oscillator fields done");
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, A_THR, 32'h00000009 | 32'(m << 4));
			wait_n(2);
			chk("lf mode", 32'({m == 3, m == 2, m[1:0], 4'h9}),
				32'({lf_digital_input_en, very_low_power_osc_en,
				lf_source_select_hi, lf_source_select_lo,
				lf_load_cap_select, hf_range_select}));
		end
		apb(1'b1, A_THR, 32'h00000000);
		$display("test lf modes done");
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped error", 32'h1, 32'(rerr));
		chk("unmapped data", 32'h0, rdat);
		apb(1'b1, occ_pkg::ADDR_STATE, 32'hFFFFFFFF);
		rd(occ_pkg::ADDR_STATE, 32'h00000000);
		apb(1'b1, A_TWO, 32'h00000003);
		repeat (3)
		begin
			wait_n(1);
			chk("clock enable", 32'h1, 32'(cpu_clk_enable));
		end
		chk("refused source", 32'(occ_pkg::SRC_DCO), 32'(cpu_clk_source));
		$display("test refused accesses done");
		apb(1'b1, A_TWO, 32'h00000002);
		wait_n(GAP + 4);
		chk("cpu source", 32'(occ_pkg::SRC_HF), 32'(cpu_clk_source));
		apb(1'b1, A_MSK, 32'h00000001);
		lf_run <= 1'b0;
		wait_n(LFT + GAP + 12);
		chk("irq", 32'h1, 32'(irq));
		chk("fault source", 32'(occ_pkg::SRC_DCO), 32'(cpu_clk_source));
		rd(A_STS, 32'h00000005);
		apb(1'b1, A_MSK, 32'h00000000);
		wait_n(2);
		chk("masked irq", 32'h0, 32'(irq));
		lf_run <= 1'b1;
		wait_n(8);
		apb(1'b1, A_STS, 32'h00000007);
		wait_n(GAP + 4);
		rd(A_STS, 32'h00000000);
		chk("restored source", 32'(occ_pkg::SRC_HF), 32'(cpu_clk_source));
		$display("test fault and switch done");
		end_of_test;
	end
endmodule

bind occ_clock_control occ_clock_control_monitor
#(.LF_TIMEOUT(LF_TIMEOUT), .SWITCH_GAP(SWITCH_GAP))
occ_clock_control_monitor_i
(
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.lf_osc_sample(lf_osc_sample), .osc_range_select(osc_range_select),
	.osc_tap_select(osc_tap_select),
	.osc_modulation_select(osc_modulation_select),
	.external_bias_select(external_bias_select),
	.hf_range_select(hf_range_select), .lf_load_cap_select(lf_load_cap_select),
	.lf_source_select_hi(lf_source_select_hi),
	.lf_source_select_lo(lf_source_select_lo),
	.lf_digital_input_en(lf_digital_input_en),
	.very_low_power_osc_en(very_low_power_osc_en),
	.cpu_clk_source(cpu_clk_source), .cpu_clk_enable(cpu_clk_enable)
);
